// >>> rtuq_pkg.sv
package rtuq_pkg;
   // ****************************************
   // Function codes and frame figures
   // ****************************************
   localparam logic [7:0] FN_RD_OUT    = 8'h01;
   localparam logic [7:0] FN_RD_IN     = 8'h02;
   localparam logic [7:0] FN_RD_REG    = 8'h03;
   localparam logic [7:0] FN_RD_AIN    = 8'h04;
   localparam logic [7:0] FN_FORCE_ONE = 8'h05;
   localparam logic [7:0] FN_PRESET    = 8'h06;
   localparam logic [7:0] FN_EXC_STAT  = 8'h07;
   localparam logic [7:0] FN_LOOPBACK  = 8'h08;
   localparam logic [7:0] FN_SCRATCH   = 8'h43;
   localparam logic [7:0] FN_FORCE_MUL = 8'h0F;
   localparam logic [7:0] FN_PRESET_MUL = 8'h10;
   localparam logic [7:0] FN_DEV_TYPE  = 8'h11;
   localparam logic [7:0] FN_MASK_WR   = 8'h16;
   localparam logic [7:0] FN_RW_REGS   = 8'h17;
   localparam logic [7:0] ERR_FLAG     = 8'h80;
   localparam logic [7:0] EXC_ILL_FN   = 8'h01;
   localparam logic [7:0] EXC_ILL_ADDR = 8'h02;
   localparam logic [7:0] EXC_ILL_DATA = 8'h03;
   localparam logic [15:0] DIAG_ECHO    = 16'h0000;
   localparam logic [15:0] DIAG_RESTART = 16'h0001;
   localparam logic [15:0] DIAG_LISTEN  = 16'h0004;
   localparam logic [7:0] COIL_ON      = 8'hFF;
   localparam logic [7:0] COIL_OFF     = 8'h00;
   localparam logic [8:0] LEN_QRY6     = 9'h006;
   localparam logic [8:0] LEN_QRY2     = 9'h002;
   localparam logic [8:0] LEN_QRY8     = 9'h008;
   localparam logic [8:0] LEN_QRY7     = 9'h007;
   localparam logic [8:0] LEN_QRY13    = 9'h00D;
   localparam logic [7:0] REG_CNT_MAX  = 8'h7D;
   localparam logic [15:0] CRC_INIT    = 16'hFFFF;
   localparam logic [15:0] CRC_POLY    = 16'hA001;
   localparam int FRAME_BYTES = 256;
   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_HZ      = 125_000_000;
   localparam int BAUD_DEF    = 19_200;
   localparam int CHAR_BITS   = 11;
   localparam int GAP_CHARS   = 4;
   localparam int GAP_CYCLES  = (CLK_HZ / BAUD_DEF) * CHAR_BITS * GAP_CHARS;
endpackage

// >>> rtuq_engine.sv
`timescale 1ns/1ns
module rtuq_engine
   import rtuq_pkg::*;
#(
   parameter int          GAP_CYC   = GAP_CYCLES,
   parameter logic [15:0] MAX_POINT = 16'h0400,
   parameter logic [15:0] MAX_INPUT = 16'h0400,
   parameter logic [15:0] MAX_REG   = 16'h0400,
   parameter logic [15:0] MAX_AIN   = 16'h0100
) (
   input  wire logic        clock,       // System clock.
   input  wire logic        rst_n,       // Asynchronous reset, active low.
   input  wire logic [7:0]  station,     // Own station address.
   input  wire logic [7:0]  rx_data,     // Received byte.
   input  wire logic        rx_valid,    // Received byte strobe.
   output logic [7:0]       tx_data,     // Byte to transmit.
   output logic             tx_valid,    // Byte offered.
   input  wire logic        tx_ready,    // Transmitter takes the byte.
   output logic [1:0]       tab_sel,     // 0 outputs, 1 inputs, 2 registers, 3 analog.
   output logic [15:0]      tab_addr,    // Zero-based table index.
   output logic             tab_rd,      // Read strobe, data sampled in the same cycle.
   input  wire logic [15:0] tab_rdata,   // Read data (bit 0 for discrete).
   output logic             tab_wr,      // Write strobe.
   output logic [15:0]      tab_wdata,   // Write data.
   output logic             listen_only  // Listen-only state.
);
   if (GAP_CYC < 1 || MAX_POINT == 16'h0000 || MAX_REG == 16'h0000) begin : g_bad_param
      $error("rtuq_engine: bad parameter");
   end

   typedef enum logic [6:0] {
      RTUQ_RX   = 7'b0000001,
      RTUQ_CHK  = 7'b0000010,
      RTUQ_EXEC = 7'b0000100,
      RTUQ_FET  = 7'b0001000,
      RTUQ_WAIT = 7'b0010000,
      RTUQ_SEND = 7'b0100000,
      RTUQ_CRC  = 7'b1000000
   } rtuq_state_t;

   function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c ^ {8'h00, d};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   // ****************************************
   // Receive side
   // ****************************************
   logic [7:0]  qry_ff [0:15];
   logic [8:0]  rcnt_ff;
   logic [15:0] rcrc_ff;
   logic [31:0] gap_ff;
   logic        done_ff;
   rtuq_state_t st_ff;
   logic [8:0]  need;
   logic        in_rx;

   assign in_rx = (st_ff == RTUQ_RX);

   always_comb begin
      need = 9'h1FF;
      if (rcnt_ff >= 9'h002) begin
         case (qry_ff[1])
            FN_RD_OUT, FN_RD_IN, FN_RD_REG, FN_RD_AIN, FN_SCRATCH,
            FN_FORCE_ONE, FN_PRESET, FN_LOOPBACK: need = LEN_QRY6 + 9'h002;
            FN_EXC_STAT, FN_DEV_TYPE: need = LEN_QRY2 + 9'h002;
            FN_MASK_WR: need = LEN_QRY8 + 9'h002;
            FN_FORCE_MUL, FN_PRESET_MUL:
               if (rcnt_ff >= 9'h007) need = LEN_QRY7 + {1'b0, qry_ff[6]} + 9'h002;
            FN_RW_REGS:
               if (rcnt_ff >= 9'h00B) need = LEN_QRY13 + {1'b0, qry_ff[10]} + 9'h002;
            default: need = 9'h1FF;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rcnt_ff <= 9'h000;
         rcrc_ff <= CRC_INIT;
         gap_ff  <= 32'h0000_0000;
         done_ff <= 1'b0;
      end else if (!in_rx) begin
         rcnt_ff <= 9'h000;
         rcrc_ff <= CRC_INIT;
         gap_ff  <= 32'h0000_0000;
         done_ff <= 1'b0;
      end else if (rx_valid) begin
         rcnt_ff <= (rcnt_ff == 9'h1FF) ? rcnt_ff : rcnt_ff + 9'h001;
         rcrc_ff <= crc_byte(rcrc_ff, rx_data);
         gap_ff  <= 32'h0000_0000;
         done_ff <= (rcnt_ff + 9'h001 == need);
      end else if (rcnt_ff != 9'h000) begin
         if (gap_ff == GAP_CYC - 1) begin
            done_ff <= 1'b1;
         end else begin
            gap_ff <= gap_ff + 32'h0000_0001;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (in_rx && rx_valid && rcnt_ff < 9'h010) begin
         qry_ff[rcnt_ff[3:0]] <= rx_data;
      end
   end

   // ****************************************
   // Decode
   // ****************************************
   logic [15:0] f_a, f_b;
   logic        bcast, mine;
   logic [16:0] span;
   assign f_a   = {qry_ff[2], qry_ff[3]};
   assign f_b   = {qry_ff[4], qry_ff[5]};
   assign bcast = (qry_ff[0] == 8'h00);
   assign mine  = (qry_ff[0] == station);
   assign span  = {1'b0, f_a} + {1'b0, f_b};

   logic [7:0]  rsp_ff [0:7];
   logic [2:0]  hlen_ff;
   logic [7:0]  bc_ff;
   logic [8:0]  dleft_ff;
   logic [15:0] idx_ff;
   logic [15:0] nleft_ff;
   logic        disc_ff;
   logic [7:0]  pack_ff;
   logic [2:0]  bit_ff;
   logic        hib_ff;
   logic [15:0] word_ff;
   logic [15:0] tcrc_ff;
   logic        crchi_ff;
   logic [2:0]  hi_ff;
   logic        bufv_ff;
   logic [7:0]  buf_ff;

   // ****************************************
   // Two-entry output buffer
   // ****************************************
   logic [7:0] fifo_ff [0:1];
   logic [1:0] fcnt_ff;
   logic       fwp_ff, frp_ff;
   logic       f_in_rdy, f_push, f_pop;
   assign f_in_rdy = (fcnt_ff != 2'd2);
   assign f_push   = bufv_ff && f_in_rdy;
   assign f_pop    = tx_valid && tx_ready;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         fcnt_ff  <= 2'd0;
         fwp_ff   <= 1'b0;
         frp_ff   <= 1'b0;
         tx_valid <= 1'b0;
         tx_data  <= 8'h00;
      end else begin
         if (f_push) begin
            fifo_ff[fwp_ff] <= buf_ff;
            fwp_ff <= ~fwp_ff;
         end
         fcnt_ff <= fcnt_ff + {1'b0, f_push} - {1'b0, f_pop};
         if (!tx_valid || f_pop) begin
            if (fcnt_ff - {1'b0, f_pop} != 2'd0) begin
               tx_valid <= 1'b1;
               tx_data  <= fifo_ff[frp_ff ^ f_pop];
               frp_ff   <= frp_ff ^ f_pop;
            end else begin
               tx_valid <= f_pop ? 1'b0 : tx_valid;
               frp_ff   <= frp_ff ^ f_pop;
            end
         end
      end
   end

   // ****************************************
   // Command sequencer
   // ****************************************
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= RTUQ_RX;
         listen_only <= 1'b0;
         tab_rd <= 1'b0;
         tab_wr <= 1'b0;
         tab_sel <= 2'd0;
         tab_addr <= 16'h0000;
         tab_wdata <= 16'h0000;
         hlen_ff <= 3'd0;
         hi_ff <= 3'd0;
         bc_ff <= 8'h00;
         dleft_ff <= 9'h000;
         idx_ff <= 16'h0000;
         nleft_ff <= 16'h0000;
         disc_ff <= 1'b0;
         pack_ff <= 8'h00;
         bit_ff <= 3'd0;
         hib_ff <= 1'b0;
         word_ff <= 16'h0000;
         tcrc_ff <= CRC_INIT;
         crchi_ff <= 1'b0;
         bufv_ff <= 1'b0;
         buf_ff <= 8'h00;
         for (int i = 0; i < 8; i++) rsp_ff[i] <= 8'h00;
      end else begin
         tab_rd <= 1'b0;
         tab_wr <= 1'b0;
         if (f_push) bufv_ff <= 1'b0;
         case (st_ff)
            RTUQ_RX: if (done_ff) st_ff <= RTUQ_CHK;
            RTUQ_CHK: begin
               if ((rcnt_ff == need || (need == 9'h1FF && rcnt_ff > 9'h003))
                   && rcrc_ff == 16'h0000 && (mine || bcast)) st_ff <= RTUQ_EXEC;
               else st_ff <= RTUQ_RX;
            end
            RTUQ_EXEC: begin
               for (int i = 0; i < 6; i++) rsp_ff[i] <= qry_ff[i];
               rsp_ff[0] <= station;
               hi_ff <= 3'd0;
               tcrc_ff <= CRC_INIT;
               disc_ff <= 1'b0;
               dleft_ff <= 9'h000;
               st_ff <= RTUQ_SEND;
               hlen_ff <= 3'd3;
               rsp_ff[1] <= ERR_FLAG | qry_ff[1];
               rsp_ff[2] <= EXC_ILL_FN;
               case (qry_ff[1])
                  FN_RD_OUT, FN_RD_IN: begin
                     if (bcast) st_ff <= RTUQ_RX;
                     else if (f_b == 16'h0000 || f_b > 16'h0800) rsp_ff[2] <= EXC_ILL_DATA;
                     else if (span > {1'b0, (qry_ff[1] == FN_RD_OUT) ? MAX_POINT : MAX_INPUT})
                        rsp_ff[2] <= EXC_ILL_ADDR;
                     else begin
                        rsp_ff[1] <= qry_ff[1];
                        bc_ff <= 8'((f_b + 16'h0007) >> 3);
                        rsp_ff[2] <= 8'((f_b + 16'h0007) >> 3);
                        dleft_ff <= 9'((f_b + 16'h0007) >> 3);
                        disc_ff <= 1'b1;
                        tab_sel <= (qry_ff[1] == FN_RD_OUT) ? 2'd0 : 2'd1;
                        idx_ff <= f_a;
                        nleft_ff <= f_b;
                     end
                  end
                  FN_RD_REG, FN_RD_AIN: begin
                     if (bcast) st_ff <= RTUQ_RX;
                     else if (f_b == 16'h0000 || f_b > {8'h00, REG_CNT_MAX})
                        rsp_ff[2] <= EXC_ILL_DATA;
                     else if (span > {1'b0, (qry_ff[1] == FN_RD_REG) ? MAX_REG : MAX_AIN})
                        rsp_ff[2] <= EXC_ILL_ADDR;
                     else begin
                        rsp_ff[1] <= qry_ff[1];
                        rsp_ff[2] <= {f_b[6:0], 1'b0};
                        dleft_ff <= {1'b0, f_b[6:0], 1'b0};
                        tab_sel <= (qry_ff[1] == FN_RD_REG) ? 2'd2 : 2'd3;
                        idx_ff <= f_a;
                        nleft_ff <= f_b;
                     end
                  end
                  FN_FORCE_ONE, FN_PRESET: begin
                     if ((qry_ff[1] == FN_FORCE_ONE) && ((qry_ff[4] != COIL_ON && qry_ff[4] != COIL_OFF)
                         || qry_ff[5] != 8'h00)) rsp_ff[2] <= EXC_ILL_DATA;
                     else if ({1'b0, f_a} >= {1'b0, (qry_ff[1] == FN_PRESET) ? MAX_REG : MAX_POINT})
                        rsp_ff[2] <= EXC_ILL_ADDR;
                     else begin
                        tab_wr <= 1'b1;
                        tab_sel <= (qry_ff[1] == FN_PRESET) ? 2'd2 : 2'd0;
                        tab_addr <= f_a;
                        tab_wdata <= (qry_ff[1] == FN_PRESET) ? f_b : {15'h0000, qry_ff[4][0]};
                        rsp_ff[1] <= qry_ff[1];
                        rsp_ff[2] <= qry_ff[2];
                        hlen_ff <= 3'd6;
                     end
                     if (bcast) st_ff <= RTUQ_RX;
                  end
                  FN_EXC_STAT: begin
                     if (bcast) st_ff <= RTUQ_RX;
                     else begin
                        rsp_ff[1] <= qry_ff[1];
                        rsp_ff[2] <= 8'h01;
                        hlen_ff <= 3'd2;
                        dleft_ff <= 9'h001;
                        disc_ff <= 1'b1;
                        tab_sel <= 2'd0;
                        idx_ff <= 16'h0000;
                        nleft_ff <= 16'h0008;
                     end
                  end
                  FN_LOOPBACK: begin
                     if (f_a == DIAG_ECHO && !bcast) begin
                        rsp_ff[1] <= qry_ff[1];
                        rsp_ff[2] <= qry_ff[2];
                        hlen_ff <= 3'd6;
                     end else if (f_a == DIAG_RESTART && (qry_ff[4] == COIL_ON
                                  || qry_ff[4] == COIL_OFF) && qry_ff[5] == 8'h00) begin
                        listen_only <= 1'b0;
                        rsp_ff[1] <= qry_ff[1];
                        rsp_ff[2] <= qry_ff[2];
                        hlen_ff <= 3'd6;
                        if (bcast) st_ff <= RTUQ_RX;
                     end else if (f_a == DIAG_LISTEN) begin
                        listen_only <= 1'b1;
                        st_ff <= RTUQ_RX;
                     end else begin
                        rsp_ff[2] <= EXC_ILL_DATA;
                        if (bcast) st_ff <= RTUQ_RX;
                     end
                  end
                  default: if (bcast) st_ff <= RTUQ_RX;
               endcase
               if (listen_only && !(qry_ff[1] == FN_LOOPBACK && f_a == DIAG_RESTART
                   && qry_ff[5] == 8'h00
                   && (qry_ff[4] == COIL_ON || qry_ff[4] == COIL_OFF))) begin
                  tab_wr <= 1'b0;
                  st_ff <= RTUQ_RX;
               end
            end
            RTUQ_SEND: begin
               if (!bufv_ff || f_push) begin
                  bufv_ff <= 1'b1;
                  if (hi_ff != hlen_ff) begin
                     buf_ff <= rsp_ff[hi_ff];
                     tcrc_ff <= crc_byte(tcrc_ff, rsp_ff[hi_ff]);
                     hi_ff <= hi_ff + 3'd1;
                  end else begin
                     bufv_ff <= 1'b0;
                     crchi_ff <= 1'b0;
                     pack_ff <= 8'h00;
                     bit_ff <= 3'd0;
                     hib_ff <= 1'b0;
                     st_ff <= (dleft_ff != 9'h000) ? RTUQ_FET : RTUQ_CRC;
                  end
               end
            end
            RTUQ_FET: begin
               if (!hib_ff && (!bufv_ff || f_push)) begin
                  if (nleft_ff != 16'h0000) begin
                     tab_rd <= 1'b1;
                     tab_addr <= idx_ff;
                     st_ff <= RTUQ_WAIT;
                  end else begin
                     buf_ff <= pack_ff;
                     bufv_ff <= 1'b1;
                     tcrc_ff <= crc_byte(tcrc_ff, pack_ff);
                     dleft_ff <= dleft_ff - 9'h001;
                     st_ff <= (dleft_ff == 9'h001) ? RTUQ_CRC : RTUQ_FET;
                  end
               end else if (hib_ff && (!bufv_ff || f_push)) begin
                  buf_ff <= word_ff[7:0];
                  bufv_ff <= 1'b1;
                  tcrc_ff <= crc_byte(tcrc_ff, word_ff[7:0]);
                  hib_ff <= 1'b0;
                  dleft_ff <= dleft_ff - 9'h001;
                  st_ff <= (dleft_ff == 9'h001) ? RTUQ_CRC : RTUQ_FET;
               end
            end
            RTUQ_WAIT: begin
               idx_ff <= idx_ff + 16'h0001;
               nleft_ff <= nleft_ff - 16'h0001;
               st_ff <= RTUQ_FET;
               if (disc_ff) begin
                  pack_ff[bit_ff] <= tab_rdata[0];
                  bit_ff <= bit_ff + 3'd1;
                  if (bit_ff == 3'd7 || nleft_ff == 16'h0001) begin
                     buf_ff <= {tab_rdata[0], 7'h00} >> (3'd7 - bit_ff) | pack_ff;
                     bufv_ff <= 1'b1;
                     tcrc_ff <= crc_byte(tcrc_ff, ({tab_rdata[0], 7'h00} >> (3'd7 - bit_ff)) | pack_ff);
                     pack_ff <= 8'h00;
                     bit_ff <= 3'd0;
                     dleft_ff <= dleft_ff - 9'h001;
                     if (dleft_ff == 9'h001) st_ff <= RTUQ_CRC;
                  end
               end else begin
                  word_ff <= tab_rdata;
                  buf_ff <= tab_rdata[15:8];
                  bufv_ff <= 1'b1;
                  tcrc_ff <= crc_byte(tcrc_ff, tab_rdata[15:8]);
                  hib_ff <= 1'b1;
                  dleft_ff <= dleft_ff - 9'h001;
               end
            end
            RTUQ_CRC: begin
               if (!bufv_ff || f_push) begin
                  bufv_ff <= 1'b1;
                  if (!crchi_ff) begin
                     buf_ff <= tcrc_ff[7:0];
                     crchi_ff <= 1'b1;
                  end else begin
                     buf_ff <= tcrc_ff[15:8];
                     st_ff <= RTUQ_RX;
                  end
               end
            end
            default: st_ff <= RTUQ_RX;
         endcase
      end
   end
endmodule

// >>> rtuq_table_model.sv
`timescale 1ns/1ns
module rtuq_table_model
   import rtuq_pkg::*;
(
   input  wire logic        clock,     // System clock.
   input  wire logic [1:0]  tab_sel,   // Table select.
   input  wire logic [15:0] tab_addr,  // Table index.
   input  wire logic        tab_rd,    // Read strobe.
   input  wire logic        tab_wr,    // Write strobe.
   input  wire logic [15:0] tab_wdata, // Write data.
   output logic      [15:0] tab_rdata, // Read data.
   output logic             tx_ready   // Transmitter takes a byte.
);
   logic [1:0]  wsel;
   logic [15:0] waddr;
   logic [15:0] wdata;
   logic [15:0] junk;
   function automatic logic [15:0] pat(input logic [1:0] s, input logic [15:0] a);
      return (a * 16'h9E37) ^ {s, 14'h0A5C};
   endfunction
   initial begin
      junk = 16'h0000;
      tx_ready = 1'b0;
   end
   // Answers while the read strobe stands and shows junk otherwise, so a late sample shows.
   assign tab_rdata = tab_rd ? pat(tab_sel, tab_addr) : junk;
   always @(posedge clock) begin
      junk <= ~junk;
      tx_ready <= $urandom_range(3) != 0;
      if (tab_wr) begin
         {wsel, waddr, wdata} <= {tab_sel, tab_addr, tab_wdata};
      end
   end
endmodule

// >>> rtuq_engine_props.sv
`timescale 1ns/1ns
module rtuq_engine_props
   import rtuq_pkg::*;
#(
   parameter logic [15:0] MAX_POINT = 16'h0400,
   parameter logic [15:0] MAX_INPUT = 16'h0400,
   parameter logic [15:0] MAX_REG   = 16'h0400,
   parameter logic [15:0] MAX_AIN   = 16'h0100
) (
   input wire logic        clock,      // Clock.
   input wire logic        rst_n,      // Reset.
   input wire logic [7:0]  tx_data,    // Reply byte.
   input wire logic        tx_valid,   // Reply offered.
   input wire logic        tx_ready,   // Reply taken.
   input wire logic [1:0]  tab_sel,    // Table.
   input wire logic [15:0] tab_addr,   // Index.
   input wire logic        tab_rd,     // Read.
   input wire logic        tab_wr,     // Write.
   input wire logic [15:0] tab_wdata,  // Write data.
   input wire logic        listen_only // Silent state.
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   sequence s_stalled;
      tx_valid && !tx_ready;
   endsequence
   sequence s_one_write;
      tab_wr ##1 !tab_wr;
   endsequence
   sequence s_touch(logic [1:0] sel);
      (tab_rd || tab_wr) && tab_sel == sel;
   endsequence
   chk_tx_hold: assert property (s_stalled |=> tx_valid && $stable(tx_data))
      else $error("Reply byte changed before it was taken.");
   chk_wr_pulse: assert property (tab_wr |-> s_one_write)
      else $error("Write strobe longer than one cycle.");
   chk_wr_table: assert property (tab_wr |-> tab_sel == 2'h0 || tab_sel == 2'h2)
      else $error("Write to a read-only table.");
   chk_coil_bit: assert property (tab_wr && tab_sel == 2'h0 |-> tab_wdata[15:1] == 15'h0000)
      else $error("Output force carries more than one bit.");
   chk_out_bound: assert property (s_touch(2'h0) |-> tab_addr < MAX_POINT)
      else $error("Output index past the top.");
   chk_in_bound: assert property (s_touch(2'h1) |-> tab_addr < MAX_INPUT)
      else $error("Input index past the top.");
   chk_reg_bound: assert property (s_touch(2'h2) |-> tab_addr < MAX_REG)
      else $error("Register index past the top.");
   chk_ain_bound: assert property (s_touch(2'h3) |-> tab_addr < MAX_AIN)
      else $error("Analog index past the top.");
   chk_listen_quiet: assert property (listen_only |-> !tx_valid && !tab_rd && !tab_wr)
      else $error("Activity while silent.");
   chk_reset_clean: assert property ($rose(rst_n) |-> !tx_valid && !listen_only ##1 !tx_valid)
      else $error("Output active right after reset.");
endmodule

// >>> rtuq_engine_test.sv
`timescale 1ns/1ns
module rtuq_engine_test
   import rtuq_pkg::*;
;
   localparam int          GAP = 200;
   localparam logic [15:0] LIM = 16'h0800;
   localparam logic [7:0]  ST  = 8'h11;
   logic        clock;
   logic        rst_n;
   logic [7:0]  rx_data;
   logic        rx_valid;
   logic [7:0]  tx_data;
   logic        tx_valid;
   logic        tx_ready;
   logic [1:0]  tab_sel;
   logic [15:0] tab_addr;
   logic        tab_rd;
   logic [15:0] tab_rdata;
   logic        tab_wr;
   logic [15:0] tab_wdata;
   logic        listen_only;
   logic [7:0]  rxq[$];
   logic [7:0]  expq[$];
   logic [7:0]  gotq[$];
   logic [7:0]  fc;
   logic [15:0] s;
   logic [15:0] n;
   logic [15:0] d;
   logic [7:0]  efc[4] = '{8'h03, 8'h04, 8'h03, 8'h01};
   logic [15:0] es[4]  = '{16'h0000, 16'h0000, LIM - 16'h0001, LIM};
   logic [15:0] en[4]  = '{16'h007E, 16'h0000, 16'h0002, 16'h0001};
   logic [7:0]  eex[4] = '{EXC_ILL_DATA, EXC_ILL_DATA, EXC_ILL_ADDR, EXC_ILL_ADDR};
   int          err_total;
   int          checked;
   rtuq_engine #(
      .GAP_CYC(GAP), .MAX_POINT(LIM), .MAX_INPUT(LIM), .MAX_REG(LIM), .MAX_AIN(LIM)
   ) rtuq_engine_i (
      .clock(clock), .rst_n(rst_n), .station(ST), .rx_data(rx_data),
      .rx_valid(rx_valid), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .tab_sel(tab_sel), .tab_addr(tab_addr), .tab_rd(tab_rd), .tab_rdata(tab_rdata),
      .tab_wr(tab_wr), .tab_wdata(tab_wdata), .listen_only(listen_only)
   );
   rtuq_table_model rtuq_table_model_i (
      .clock(clock), .tab_sel(tab_sel), .tab_addr(tab_addr), .tab_rd(tab_rd),
      .tab_wr(tab_wr), .tab_wdata(tab_wdata), .tab_rdata(tab_rdata), .tx_ready(tx_ready)
   );
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   always @(posedge clock) begin
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
         gotq.push_back(tx_data);
      end
   end
   function automatic logic [15:0] crc16(input logic [7:0] q[$]);
      logic [15:0] c;
      c = CRC_INIT;
      foreach (q[i]) begin
         c = c ^ {8'h00, q[i]};
         repeat (8) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
      end
      return c;
   endfunction
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   function automatic void q6(input logic [7:0] st, fc, input logic [15:0] a, d);
      rxq = {st, fc, a[15:8], a[7:0], d[15:8], d[7:0]};
   endfunction
   function automatic void rd_exp(input logic [7:0] fc, input logic [15:0] s, n);
      logic [7:0]  b;
      logic [15:0] w;
      b = 8'h00;
      expq = {ST, fc, fc > 8'h02 ? 8'(2 * n) : 8'((n + 7) / 8)};
      for (int i = 0; i < n; i++) begin
         w = rtuq_table_model_i.pat(2'(fc - 8'h01), s + 16'(i));
         if (fc > 8'h02) begin
            expq.push_back(w[15:8]);
            expq.push_back(w[7:0]);
         end else begin
            b[i % 8] = w[0];
            if (i % 8 == 7 || i == n - 1) begin
               expq.push_back(b);
               b = 8'h00;
            end
         end
      end
   endfunction
   task automatic run(input string name, input logic bad);
      logic [15:0] c;
      int          idle;
      if (expq.size() > 0) begin
         c = crc16(expq);
         expq.push_back(c[7:0]);
         expq.push_back(c[15:8]);
      end
      c = crc16(rxq) ^ {15'h0000, bad};
      rxq.push_back(c[7:0]);
      rxq.push_back(c[15:8]);
      gotq = {};
      foreach (rxq[i]) begin
         @(posedge clock);
         #1 rx_data = rxq[i];
         rx_valid = 1'b1;
         @(posedge clock);
         #1 rx_valid = 1'b0;
         repeat ($urandom_range(2)) @(posedge clock);
      end
      idle = 0;
      while (idle < 2 * GAP) begin
         @(posedge clock);
         idle = tx_valid === 1'b1 ? 0 : idle + 1;
      end
      chk("reply length", 16'(gotq.size()), 16'(expq.size()));
      foreach (expq[i]) chk("reply byte", {8'h00, gotq[i]}, {8'h00, expq[i]});
      $display("test %s done", name);
   endtask
   task automatic final_report();
      $display("checked %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      #(8 * 80_000);
      err_total++;
      final_report();
   end
   initial begin
      rx_data = 8'h00;
      rx_valid = 1'b0;
      rst_n = 1'b0;
      err_total = 0;
      checked = 0;
      void'($urandom(32'hD68420F8));
      repeat (5) @(posedge clock);
      #1 rst_n = 1'b1;
      for (int k = 0; k < 8; k++) begin
         fc = 8'(k % 4 + 1);
         n = k < 4 ? (fc < 8'h03 ? LIM : 16'h007D) :
             16'($urandom_range(fc < 8'h03 ? 64 : 125, 1));
         s = k < 4 ? LIM - n : 16'($urandom_range(LIM - n));
         q6(ST, fc, s, n);
         rd_exp(fc, s, n);
         run("table read", 1'b0);
      end
      for (int k = 0; k < 4; k++) begin
         q6(ST, efc[k], es[k], en[k]);
         expq = {ST, efc[k] | ERR_FLAG, eex[k]};
         run("refused query", 1'b0);
      end
      q6(ST, 8'h09, 16'h0000, 16'h0001);
      expq = {ST, 8'h89, EXC_ILL_FN};
      run("undefined code", 1'b0);
      rxq = {ST, FN_DEV_TYPE};
      expq = {ST, FN_DEV_TYPE | ERR_FLAG, EXC_ILL_FN};
      run("device type", 1'b0);
      rxq = {ST, FN_EXC_STAT};
      rd_exp(FN_RD_OUT, 16'h0000, 16'h0008);
      expq[1] = FN_EXC_STAT;
      expq.delete(2);
      run("exception status", 1'b0);
      for (int k = 0; k < 3; k++) begin
         q6(k == 1 ? 8'h22 : (k == 2 ? 8'h00 : ST), FN_RD_OUT, 16'h0000, 16'h0008);
         expq = {};
         run("silent frame", k == 0);
      end
      for (int k = 0; k < 3; k++) begin
         d = k == 2 ? 16'($urandom) : {k == 0 ? COIL_ON : COIL_OFF, 8'h00};
         s = 16'($urandom_range(LIM - 1));
         q6(k == 2 ? 8'h00 : ST, k == 2 ? FN_PRESET : FN_FORCE_ONE, s, d);
         expq = rxq;
         if (k == 2) begin
            expq = {};
         end
         run("single write", 1'b0);
         chk("write table", {14'h0000, rtuq_table_model_i.wsel}, {14'h0000, k == 2, 1'b0});
         chk("write index", rtuq_table_model_i.waddr, s);
         chk("write value", rtuq_table_model_i.wdata, k == 2 ? d : {15'h0000, k == 0});
      end
      q6(ST, FN_LOOPBACK, DIAG_ECHO, 16'($urandom));
      expq = rxq;
      run("echo", 1'b0);
      q6(ST, FN_LOOPBACK, DIAG_LISTEN, 16'h0000);
      expq = {};
      run("listen", 1'b0);
      chk("silent state", {15'h0000, listen_only}, 16'h0001);
      q6(ST, FN_RD_REG, 16'h0000, 16'h0001);
      run("silent read", 1'b0);
      q6(8'h00, FN_LOOPBACK, DIAG_RESTART, 16'h0000);
      run("restart", 1'b0);
      chk("silent state", {15'h0000, listen_only}, 16'h0000);
      q6(ST, FN_RD_REG, 16'h0000, 16'h0001);
      rd_exp(FN_RD_REG, 16'h0000, 16'h0001);
      run("read after restart", 1'b0);
      final_report();
   end
endmodule
bind rtuq_engine rtuq_engine_props #(
   .MAX_POINT(MAX_POINT), .MAX_INPUT(MAX_INPUT), .MAX_REG(MAX_REG), .MAX_AIN(MAX_AIN)
) rtuq_engine_props_i (
   .clock(clock), .rst_n(rst_n), .tx_data(tx_data), .tx_valid(tx_valid),
   .tx_ready(tx_ready), .tab_sel(tab_sel), .tab_addr(tab_addr), .tab_rd(tab_rd),
   .tab_wr(tab_wr), .tab_wdata(tab_wdata), .listen_only(listen_only)
);
